// ---- verilog/mbm_matrix.sv ----
// Multilayer bus matrix: decoders, per-slave arbiters, boot and remap
`timescale 1ns/1ps
`include "mbm_regs.svh"

module mbm_matrix
    import mbm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Boot select pin
    input wire logic boot_memory_select_pin_i,
    // Master requests
    input wire mbm_mst_req_t [11:0] mst_req_i,
    // Master answers
    output logic [11:0] mst_grant_o,
    output logic [11:0] mst_err_o,
    output logic [11:0][3:0] mst_slv_o,
    // Slave ownership
    output mbm_owner_t [9:0] slv_owner_o,
    output logic [9:0] slv_busy_o,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);

    mbm_state_t state;
    mbm_state_t next_state;

    // Allowed masters of a slave, bit m is master m
    // R10
    function automatic logic [11:0] path_mask(input logic [3:0] s);
        logic [11:0] m;
        m = `MBM_PATH_ALL;
        if (s == `MBM_S_CTRL) begin
            m = `MBM_PATH_CTRL; // R13
        end else if (s == `MBM_S_PER) begin
            m = `MBM_PATH_PER; // R13
        end
        return m;
    endfunction

    // Address map, identical for every master except the DDR region, which follows each master's ddr_sel bit
    function automatic mbm_dec_t decode(
        input logic [31:0] a,
        input logic remap,
        input logic boot_ext,
        input logic ddr3
    );
        mbm_dec_t d;
        logic [3:0] r;
        d.ok = 1'b1;
        d.slv = `MBM_S_SRAM;
        r = a[31:28];
        if (r == `MBM_RGN_BOOT) begin
            if (remap) begin
                d.slv = `MBM_S_SRAM; // R09
            end else if (boot_ext) begin
                d.slv = `MBM_S_EXT; // R07
            end else begin
                d.slv = `MBM_S_ROM; // R07
            end
        end else if (r == `MBM_RGN_ROM) begin
            d.slv = `MBM_S_ROM;
        end else if (r == `MBM_RGN_SRAM) begin
            d.slv = `MBM_S_SRAM;
        end else if (r == `MBM_RGN_LMEM) begin
            d.slv = `MBM_S_LMEM; // R11
        end else if (r == `MBM_RGN_CTRL) begin
            d.slv = `MBM_S_CTRL; // R12
        end else if (r == `MBM_RGN_LCS) begin
            d.slv = `MBM_S_LCS;
        end else if (r == `MBM_RGN_LPER) begin
            d.slv = `MBM_S_LPER;
        end else if (r == `MBM_RGN_DDR) begin
            d.slv = ddr3 ? `MBM_S_DDR3 : `MBM_S_DDR2; // R14
        end else if (r >= `MBM_RGN_EXT_LO && r <= `MBM_RGN_EXT_HI) begin
            d.slv = `MBM_S_EXT;
        end else if (r == `MBM_RGN_PER) begin
            d.slv = `MBM_S_PER;
        end else begin
            d.ok = 1'b0;
        end
        return d;
    endfunction

    always_comb begin
        mbm_dec_t dec;
        logic [9:0][11:0] reqv;
        logic [11:0] cand;
        logic [3:0] own;
        logic [3:0] win;
        logic hold;
        logic expired;
        logic [5:0] widx;
        logic [3:0] ridx;
        logic [11:0] pm;
        next_state = state;
        pm = 12'h000;
        reqv = '0;
        cand = '0;
        own = 4'h0;
        win = 4'h0;
        hold = 1'b0;
        expired = 1'b0;
        widx = 6'h00;
        ridx = 4'h0;
        dec = '0;

        // Boot pin synchroniser runs through reset too
        next_state.pin_s1 = boot_memory_select_pin_i;
        next_state.pin_s2 = state.pin_s1;

        // One decoder per master
        next_state.err = '0;
        for (int m = 0; m < `MBM_NUM_MST; m++) begin // R01
            dec = decode(mst_req_i[m].addr, state.remap, state.boot_ext,
                state.ddr_sel[m]); // R06
            next_state.mslv[m] = dec.slv;
            pm = path_mask(dec.slv);
            if (mst_req_i[m].req) begin
                if (dec.ok && pm[m]) begin
                    reqv[dec.slv][m] = 1'b1;
                end else begin
                    next_state.err[m] = 1'b1; // R13
                end
            end
        end

        // Independent arbiter per slave
        for (int s = 0; s < `MBM_NUM_SLV; s++) begin // R04
            own = state.owner[s].idx;
            hold = state.busy[s] && reqv[s][own];
            expired = (state.cfg[s].slot != 8'h00) &&
                (state.cnt[s] >= state.cfg[s].slot); // R05
            cand = reqv[s];
            if (hold && expired && |(cand & ~(12'h001 << own))) begin
                cand[own] = 1'b0; // R05
                hold = 1'b0;
            end
            if (hold) begin
                // Undefined-length burst keeps the layer
                if (state.cnt[s] != 8'hff) begin
                    next_state.cnt[s] = state.cnt[s] + 8'h01; // R05
                end
            end else if (|cand) begin
                win = 4'h0;
                if (state.cfg[s].rr) begin
                    for (int k = `MBM_NUM_MST; k >= 1; k--) begin
                        widx = 6'(own) + 6'(k);
                        ridx = (widx >= 6'd12) ? 4'(widx - 6'd12) : 4'(widx);
                        if (cand[ridx]) begin
                            win = ridx; // R03
                        end
                    end
                end else begin
                    for (int m = `MBM_NUM_MST - 1; m >= 0; m--) begin
                        if (cand[m]) begin
                            win = 4'(m); // R03
                        end
                    end
                end
                next_state.owner[s].idx = win;
                next_state.owner[s].valid = 1'b1;
                next_state.busy[s] = 1'b1;
                next_state.cnt[s] = 8'h01;
            end else begin
                next_state.busy[s] = 1'b0;
                next_state.cnt[s] = 8'h00;
                unique case (state.cfg[s].defm)
                    MBM_DEF_NONE: begin
                        next_state.owner[s].valid = 1'b0; // R03
                    end
                    MBM_DEF_LAST: begin
                        next_state.owner[s] = state.owner[s]; // R03
                    end
                    MBM_DEF_FIXED: begin
                        next_state.owner[s].idx = state.cfg[s].fix; // R03
                        next_state.owner[s].valid = 1'b1;
                    end
                    default: begin
                        next_state.owner[s].valid = 1'b0;
                    end
                endcase
            end
        end

        // Grants: each master may hold its own slave concurrently
        next_state.grant = '0;
        for (int s = 0; s < `MBM_NUM_SLV; s++) begin
            if (next_state.busy[s]) begin
                next_state.grant[next_state.owner[s].idx] = 1'b1; // R02
            end
        end

        // Register writes
        if (reg_wr_i) begin
            if (reg_addr_i < `MBM_OFS_REMAP && reg_addr_i[1:0] == 2'b00 &&
                reg_addr_i[7:2] < 6'd10) begin
                next_state.cfg[reg_addr_i[5:2]].rr =
                    reg_wdata_i[`MBM_F_RR]; // R03
                next_state.cfg[reg_addr_i[5:2]].defm =
                    mbm_defm_t'(reg_wdata_i[`MBM_F_DEF_HI:`MBM_F_DEF_LO]);
                next_state.cfg[reg_addr_i[5:2]].fix =
                    reg_wdata_i[`MBM_F_FIX_HI:`MBM_F_FIX_LO];
                next_state.cfg[reg_addr_i[5:2]].slot =
                    reg_wdata_i[`MBM_F_SLOT_HI:`MBM_F_SLOT_LO]; // R05
            end else if (reg_addr_i == `MBM_OFS_REMAP) begin
                next_state.remap = reg_wdata_i[0]; // R09
            end else if (reg_addr_i == `MBM_OFS_DDR) begin
                next_state.ddr_sel = reg_wdata_i[11:0]; // R14
            end
        end

        // Register reads, data valid for one cycle only
        next_state.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i < `MBM_OFS_REMAP && reg_addr_i[1:0] == 2'b00 &&
                reg_addr_i[7:2] < 6'd10) begin
                next_state.rdata[`MBM_F_RR] = state.cfg[reg_addr_i[5:2]].rr;
                next_state.rdata[`MBM_F_DEF_HI:`MBM_F_DEF_LO] =
                    state.cfg[reg_addr_i[5:2]].defm;
                next_state.rdata[`MBM_F_FIX_HI:`MBM_F_FIX_LO] =
                    state.cfg[reg_addr_i[5:2]].fix;
                next_state.rdata[`MBM_F_SLOT_HI:`MBM_F_SLOT_LO] =
                    state.cfg[reg_addr_i[5:2]].slot;
            end else if (reg_addr_i == `MBM_OFS_REMAP) begin
                next_state.rdata[0] = state.remap;
            end else if (reg_addr_i == `MBM_OFS_DDR) begin
                next_state.rdata[11:0] = state.ddr_sel;
            end else if (reg_addr_i == `MBM_OFS_STAT) begin
                next_state.rdata[0] = state.boot_ext;
                next_state.rdata[1] = state.remap;
                next_state.rdata[`MBM_F_BUSY_LO +: 10] = state.busy;
            end
        end

        // Synchronous reset; boot pin is caught while reset is held
        if (!rst_n_i) begin
            next_state.boot_ext = state.pin_s2; // R08
            next_state.remap = 1'b0; // R15
            next_state.ddr_sel = `MBM_DDR_RST;
            for (int s = 0; s < `MBM_NUM_SLV; s++) begin
                next_state.cfg[s].rr = 1'b0;
                next_state.cfg[s].defm = MBM_DEF_LAST;
                next_state.cfg[s].fix = 4'h0;
                next_state.cfg[s].slot = `MBM_SLOT_RST;
            end
            next_state.owner = '0;
            next_state.busy = '0;
            next_state.cnt = '0;
            next_state.grant = '0;
            next_state.err = '0;
            next_state.mslv = '0;
            next_state.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        state <= next_state;
    end

    assign mst_grant_o = state.grant;
    assign mst_err_o = state.err;
    assign mst_slv_o = state.mslv;
    assign slv_owner_o = state.owner;
    assign slv_busy_o = state.busy;
    assign reg_rdata_o = state.rdata;

endmodule

// ---- verilog/mbm_regs.svh ----
// Constants of the multilayer bus matrix: map, offsets, fields, resets
// Function
// R01 - Twelve masters, indices 0 to 11, each with its own layer.
// R02 - Masters proceed concurrently whenever their target slaves differ.
// R03 - Per-slave fixed priority or round robin with three default-master modes.
// R04 - Ten slaves, each with an independent arbiter and its own settings.
// R05 - Bursts of any length; break at programmable slot cycle limit.
// R06 - One decoder per master; every decoder uses the same map; here the DDR region follows each master's ddr_sel bit.
// R07 - Boot region targets internal boot, external boot or remap slave.
// R08 - Boot memory choice comes from boot select pin sampled in reset.
// R09 - Remap command places internal SRAM at the boot region.
// R10 - Master numbering: processor, DMA, video, USB, MAC, logic masters.
// R11 - Slave numbering: SRAM, ROM layer, shared ctrl, memories, DDR, peripherals.
// R12 - Low-bandwidth controller register interfaces share one slave layer.
// R13 - Some master-to-slave paths are absent and get refused.
// R14 - Per-master remap setting picks DDR port 2 or port 3.
// R15 - Reset clears remap so sampled boot memory sits at boot region.
`ifndef MBM_REGS_SVH
`define MBM_REGS_SVH

`define MBM_NUM_MST 12
`define MBM_NUM_SLV 10

// Slave indices
`define MBM_S_SRAM 4'h0
`define MBM_S_ROM 4'h1
`define MBM_S_CTRL 4'h2
`define MBM_S_LMEM 4'h3
`define MBM_S_EXT 4'h4
`define MBM_S_DDR2 4'h5
`define MBM_S_DDR3 4'h6
`define MBM_S_LCS 4'h7
`define MBM_S_LPER 4'h8
`define MBM_S_PER 4'h9

// Address regions, selected by address bits 31:28
`define MBM_RGN_BOOT 4'h0
`define MBM_RGN_ROM 4'h1
`define MBM_RGN_SRAM 4'h2
`define MBM_RGN_LMEM 4'h3
`define MBM_RGN_CTRL 4'h4
`define MBM_RGN_LCS 4'h5
`define MBM_RGN_LPER 4'h6
`define MBM_RGN_DDR 4'h7
`define MBM_RGN_EXT_LO 4'h8
`define MBM_RGN_EXT_HI 4'hb
`define MBM_RGN_PER 4'hf

// Masters allowed per slave (bit m = master m)
`define MBM_PATH_CTRL 12'he43
`define MBM_PATH_PER 12'he47
`define MBM_PATH_ALL 12'hfff

// Register offsets
`define MBM_OFS_ARB 8'h00
`define MBM_OFS_REMAP 8'h40
`define MBM_OFS_DDR 8'h44
`define MBM_OFS_STAT 8'h48

// Arbiter configuration fields
`define MBM_F_RR 0
`define MBM_F_DEF_LO 1
`define MBM_F_DEF_HI 2
`define MBM_F_FIX_LO 4
`define MBM_F_FIX_HI 7
`define MBM_F_SLOT_LO 8
`define MBM_F_SLOT_HI 15
`define MBM_F_BUSY_LO 16

// Reset values
`define MBM_SLOT_RST 8'h10
`define MBM_DDR_RST 12'h000

`endif

// ---- verilog/mbm_pkg.sv ----
// Types shared by the multilayer bus matrix
package mbm_pkg;

    typedef enum logic [1:0] {
        MBM_DEF_NONE,
        MBM_DEF_LAST,
        MBM_DEF_FIXED
    } mbm_defm_t;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } mbm_mst_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] idx;
    } mbm_owner_t;

    typedef struct packed {
        logic ok;
        logic [3:0] slv;
    } mbm_dec_t;

    typedef struct packed {
        logic rr;
        mbm_defm_t defm;
        logic [3:0] fix;
        logic [7:0] slot;
    } mbm_arb_cfg_t;

    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic boot_ext;
        logic remap;
        logic [11:0] ddr_sel;
        mbm_arb_cfg_t [9:0] cfg;
        mbm_owner_t [9:0] owner;
        logic [9:0] busy;
        logic [9:0][7:0] cnt;
        logic [11:0] grant;
        logic [11:0] err;
        logic [11:0][3:0] mslv;
        logic [31:0] rdata;
    } mbm_state_t;

endpackage

// ---- test/mbm_master_model.sv ----
// Bus master model: holds a request through its burst
`timescale 1ns/1ps

module mbm_master_model
    import mbm_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Bench control
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [31:0] addr_i,
    input wire logic [7:0] len_i,
    // Matrix side
    input wire logic grant_i,
    output mbm_mst_req_t req_o
);
    logic [7:0] left = 8'h00;
    initial req_o = '0;
    // A released address shows the inverse of its last value
    always @(posedge sys_clk_i) begin
        if (start_i) begin
            req_o <= {1'b1, addr_i};
            left <= len_i;
        end else if (stop_i || (req_o.req && grant_i && left == 8'h01)) begin
            req_o <= {1'b0, ~req_o.addr};
        end else if (req_o.req && grant_i) begin
            left <= left - 8'h01;
        end
    end
endmodule

// ---- test/mbm_matrix_monitor.sv ----
// Port checker of the multilayer bus matrix
`timescale 1ns/1ps
`include "mbm_regs.svh"

module mbm_matrix_monitor
    import mbm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Masters
    input wire mbm_mst_req_t [11:0] mst_req_i,
    input wire logic [11:0] mst_grant_o,
    input wire logic [11:0] mst_err_o,
    input wire logic [11:0][3:0] mst_slv_o,
    // Slaves
    input wire mbm_owner_t [9:0] slv_owner_o,
    input wire logic [9:0] slv_busy_o
);
    localparam logic [11:0] CTRL_OK = `MBM_PATH_CTRL;
    localparam logic [11:0] PER_OK = `MBM_PATH_PER;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    for (genvar m = 0; m < 12; m++) begin : g_mst
        sequence s_burst_end;
            mst_req_i[m].req ##1 !mst_req_i[m].req;
        endsequence
        sequence s_req_to(logic [3:0] rgn);
            mst_req_i[m].req && mst_req_i[m].addr[31:28] == rgn;
        endsequence
        a_grant_needs_req: assert property (
            mst_grant_o[m] |-> $past(mst_req_i[m].req))
            else $error("grant without request");
        a_burst_end_drop: assert property (
            s_burst_end |=> !mst_grant_o[m])
            else $error("grant kept after burst end");
        a_err_no_grant: assert property (
            mst_err_o[m] |-> !mst_grant_o[m])
            else $error("refused master granted");
        a_shared_path: assert property (
            s_req_to(`MBM_RGN_CTRL) |=> mst_err_o[m] == !CTRL_OK[m])
            else $error("shared layer path wrong");
        a_periph_path: assert property (
            s_req_to(`MBM_RGN_PER) |=> mst_err_o[m] == !PER_OK[m])
            else $error("peripheral path wrong");
        a_sram_decode: assert property (
            s_req_to(`MBM_RGN_SRAM) |=> mst_slv_o[m] == `MBM_S_SRAM)
            else $error("sram region misdecoded");
        a_owner_match: assert property (
            mst_grant_o[m] |-> slv_busy_o[mst_slv_o[m]] &&
            slv_owner_o[mst_slv_o[m]].idx == 4'(m))
            else $error("granted master not owner");
    end
    for (genvar s = 0; s < 10; s++) begin : g_slv
        a_owner_granted: assert property (
            slv_busy_o[s] |-> slv_owner_o[s].valid &&
            mst_grant_o[slv_owner_o[s].idx])
            else $error("busy slave owner not granted");
    end
endmodule

bind mbm_matrix mbm_matrix_monitor mbm_matrix_monitor_i (.sys_clk_i,
    .rst_n_i, .mst_req_i, .mst_grant_o, .mst_err_o, .mst_slv_o,
    .slv_owner_o, .slv_busy_o);

// ---- test/mbm_matrix_tb.sv ----
// Self-checking bench of the multilayer bus matrix
`timescale 1ns/1ps

module mbm_matrix_tb
    import mbm_pkg::*;
;
    localparam logic [10:0][3:0] RGN = 44'h0123_4567_8bf;
    localparam logic [10:0][3:0] SLV = 44'h4103_2785_449;
    logic sys_clk_i;
    logic rst_n_i;
    logic boot_memory_select_pin_i;
    wire mbm_mst_req_t [11:0] mst_req_i;
    logic [11:0] mst_grant_o;
    logic [11:0] mst_err_o;
    logic [11:0][3:0] mst_slv_o;
    mbm_owner_t [9:0] slv_owner_o;
    logic [9:0] slv_busy_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic [11:0] start_v;
    logic [11:0] stop_v;
    logic [11:0][31:0] addr_v;
    logic [11:0][7:0] len_v;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;

    mbm_matrix mbm_matrix_i (.sys_clk_i, .rst_n_i, .boot_memory_select_pin_i,
        .mst_req_i, .mst_grant_o, .mst_err_o, .mst_slv_o, .slv_owner_o,
        .slv_busy_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o);
    for (genvar m = 0; m < 12; m++) begin : g_mst
        mbm_master_model mbm_master_model_i (.sys_clk_i, .start_i(start_v[m]),
            .stop_i(stop_v[m]), .addr_i(addr_v[m]), .len_i(len_v[m]),
            .grant_i(mst_grant_o[m]), .req_o(mst_req_i[m]));
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp(reg_rdata_o, exp);
        // Read data stand for one cycle only
        @(posedge sys_clk_i);
        #1 cmp(reg_rdata_o, 32'h0);
    endtask
    // Called right after a clock edge; pulse() then ends the start strobe
    task automatic go(input int m, input logic [31:0] a, input logic [7:0] l);
        addr_v[m] <= a;
        len_v[m] <= l;
        start_v[m] <= 1'b1;
    endtask
    task automatic pulse();
        @(posedge sys_clk_i);
        start_v <= '0;
        stop_v <= '0;
    endtask
    // One-beat access; e holds err, grant and slave index
    task automatic acc(input int m, input logic [31:0] a, input logic [5:0] e);
        @(posedge sys_clk_i);
        go(m, a, 8'h01);
        pulse();
        look(1);
        if (e[5]) begin
            cmp(32'({mst_err_o[m], mst_grant_o[m]}), 32'(e[5:4]));
            @(posedge sys_clk_i);
            stop_v[m] <= 1'b1;
            pulse();
        end else begin
            cmp(32'({mst_err_o[m], mst_grant_o[m], mst_slv_o[m]}), 32'(e));
        end
        look(3);
    endtask
    task automatic wait_any(input logic [11:0] mask, input logic [11:0] exp);
        repeat (40) begin
            look(1);
            if ((mst_grant_o & mask) != 12'h000) break;
        end
        cmp(32'(mst_grant_o & mask), 32'(exp));
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        boot_memory_select_pin_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        start_v = '0;
        stop_v = '0;
        addr_v = '0;
        len_v = '0;
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(8'h48, 32'h1);
        rd(8'h00, 32'h1002);
        rd(8'h24, 32'h1002);
        rd(8'h4c, 32'h0);
        for (int i = 0; i < 11; i++) acc(0, {RGN[i], 28'h0}, {2'b01, SLV[i]});
        for (int m = 0; m < 12; m++) acc(m, 32'h3000_0000, 6'h13);
        acc(7, 32'hf000_0000, 6'h20);
        acc(2, 32'hf000_0000, 6'h19);
        acc(3, 32'h4000_0000, 6'h20);
        acc(6, 32'h4000_0000, 6'h12);
        acc(0, 32'hc000_0000, 6'h20);
        wr(8'h40, 32'h1);
        acc(1, 32'h0, 6'h10);
        rd(8'h48, 32'h3);
        wr(8'h40, 32'h0);
        acc(1, 32'h0, 6'h14);
        wr(8'h44, 32'h4);
        acc(2, 32'h7000_0000, 6'h16);
        acc(3, 32'h7000_0000, 6'h15);
        wr(8'h44, 32'h0);
        @(posedge sys_clk_i);
        go(0, 32'h2000_0000, 8'h03);
        go(1, 32'h1000_0000, 8'h03);
        go(3, 32'h2000_0000, 8'h03);
        go(5, 32'h2000_0000, 8'h03);
        pulse();
        look(1);
        cmp(32'(mst_grant_o), 32'h003);
        wait_any(12'h028, 12'h008);
        wait_any(12'h020, 12'h020);
        look(6);
        wr(8'h00, 32'h0203);
        @(posedge sys_clk_i);
        go(4, 32'h2000_0000, 8'hff);
        go(8, 32'h2000_0000, 8'hff);
        pulse();
        wait_any(12'h110, 12'h100);
        rd(8'h48, 32'h0001_0001);
        wait_any(12'h010, 12'h010);
        wait_any(12'h100, 12'h100);
        @(posedge sys_clk_i);
        stop_v <= 12'h110;
        pulse();
        look(4);
        for (int d = 0; d < 3; d++) begin
            wr(8'h0c, {24'h0, 4'h9, 1'b0, 2'(d), 1'b1});
            acc(6, 32'h3000_0000, 6'h13);
            cmp(d == 0 ? 32'(slv_owner_o[3].valid) : 32'(slv_owner_o[3]),
                d == 2 ? 32'h19 : (d == 1 ? 32'h16 : 32'h0));
        end
        final_report();
    end
endmodule
